// File: src/axd_regs.svh
// Offsets, field positions, encodings and reset values for the transfer decoder
`ifndef AXD_REGS_SVH
`define AXD_REGS_SVH

// Instruction encodings (10-bit words)
`define AXD_OPC_LOAD_TIMER 10'h20D
`define AXD_OPC_CLOCK_CTL 10'h216
`define AXD_OPC_TIMER_OPT 10'h2AA
// Store-with-XOR: fixed upper six bits, immediate in the low four
`define AXD_OPC_STORE_XOR_HI 6'h2B
`define AXD_OPC_HI_MSB 9
`define AXD_OPC_HI_LSB 4
`define AXD_IMM_MSB 3
`define AXD_IMM_LSB 0

// Register port offsets
`define AXD_OFS_CTRL 4'h0
`define AXD_OFS_TIMER_COUNT 4'h1
`define AXD_OFS_TIMER_RELOAD 4'h2
`define AXD_OFS_CLOCK_CTL 4'h3
`define AXD_OFS_TIMER_OPT 4'h4
`define AXD_OFS_FILE_INDEX 4'h5
`define AXD_OFS_STATUS 4'h6
`define AXD_OFS_XFER_COUNT 4'h7

// Control register fields
`define AXD_CTRL_EN_BIT 0
`define AXD_CTRL_RST 1'h1

// Status register fields
`define AXD_STAT_OP_MSB 2
`define AXD_STAT_OP_LSB 0

// Reset values of the destination registers
`define AXD_NIB_RST 4'h0
`define AXD_TOPT_RST 1'h0
`define AXD_CNT_RST 8'h00

`endif

// File: src/axd_pkg.sv
// Types shared by the accumulator transfer decoder
package axd_pkg;

    // Decoded transfer kind, also shown in the status register
    typedef enum logic [2:0] {
        op_none,
        op_load_timer_count,
        op_store_acc_xor,
        op_write_clock_ctl,
        op_write_timer_opt
    } axd_op_t;

endpackage

// File: src/axd_ldreg.sv
// Loadable register with synchronous reset, one per destination
`timescale 1ns/10ps
module axd_ldreg #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] q_o
);

    // Held value
    logic [WIDTH-1:0] val_q;
    // Next value
    logic [WIDTH-1:0] val_d;

    // Load selects new data, otherwise hold
    assign val_d = load_i ? data_i : val_q;

    // Storage flop
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            val_q <= RST_VAL;
        end else begin
            val_q <= val_d;
        end
    end

    assign q_o = val_q;

endmodule

// File: src/axd_decode.sv
// Decode and execute of the four accumulator transfer instructions
`timescale 1ns/10ps
`include "axd_regs.svh"

// Notes on behaviour
// - Word 20D loads timer count and reload
// - Store-with-XOR writes accumulator to RAM(pointer)
// - Then file index becomes index XOR immediate
// - Word 216 loads clock control register
// - Word 2AA is the timer option write
// - Only accumulator bit 0 goes to option
module axd_decode #(
    parameter int PTR_W = 6,
    parameter int CNT_W = 8
) (
    input wire logic clk_i,
    input wire logic srst_i,
    // Instruction issue from the core
    input wire logic instr_valid_i,
    input wire logic [9:0] instr_i,
    input wire logic [3:0] acc_i,
    input wire logic [PTR_W-1:0] ram_pointer_i,
    // RAM write port
    output logic ram_we_o,
    output logic [PTR_W-1:0] ram_addr_o,
    output logic [3:0] ram_wdata_o,
    // Destination registers
    output logic [3:0] timer_count_o,
    output logic [3:0] timer_count_reload_o,
    output logic [3:0] clock_control_reg_o,
    output logic timer_option_reg_o,
    output logic [3:0] file_index_o,
    // Core side effects
    output logic acc_we_o,
    output logic carry_we_o,
    output logic skip_o,
    output logic done_o,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o
);

    // Transfer counting enable from the control register
    logic ctrl_en_q;
    // Next counting enable
    logic ctrl_en_d;
    // Last decoded transfer, shown in the status register
    axd_pkg::axd_op_t last_op_q;
    // Next last transfer
    axd_pkg::axd_op_t last_op_d;
    // Executed transfer count
    logic [CNT_W-1:0] xfer_cnt_q;
    // Next transfer count
    logic [CNT_W-1:0] xfer_cnt_d;

    // RAM write strobe toward the data memory
    logic ram_we_q;
    // Next RAM write strobe
    logic ram_we_d;
    // Registered RAM nibble address
    logic [PTR_W-1:0] ram_addr_q;
    // Next RAM nibble address
    logic [PTR_W-1:0] ram_addr_d;
    // Registered RAM write data
    logic [3:0] ram_wdata_q;
    // Next RAM write data
    logic [3:0] ram_wdata_d;

    // Accumulator write request, idle for these transfers
    logic acc_we_q;
    // Next accumulator write request
    logic acc_we_d;
    // Carry write request, idle for these transfers
    logic carry_we_q;
    // Next carry write request
    logic carry_we_d;
    // Skip request, idle for these transfers
    logic skip_q;
    // Next skip request
    logic skip_d;
    // One-cycle completion pulse
    logic done_q;
    // Next completion pulse
    logic done_d;

    // Registered read data
    logic [7:0] reg_rdata_q;
    // Next read data
    logic [7:0] reg_rdata_d;

    // Opcode field of a store-with-XOR word
    logic [5:0] opc_hi;
    // Immediate field of a store-with-XOR word
    logic [3:0] imm_nib;
    // Timer count load matched
    logic hit_load_timer;
    // Store-with-XOR matched
    logic hit_store_xor;
    // Clock control write matched
    logic hit_clock_ctl;
    // Timer option write matched
    logic hit_timer_opt;
    // Any transfer executes this cycle
    logic hit_any;
    // Decoded transfer kind
    axd_pkg::axd_op_t op_now;
    // New file index after the XOR
    logic [3:0] file_index_nxt;
    // Control register write select
    logic ctrl_wr;
    // Selected register for a read
    logic [7:0] rd_mux;

    // Field split of the instruction word
    assign opc_hi = instr_i[`AXD_OPC_HI_MSB:`AXD_OPC_HI_LSB];
    assign imm_nib = instr_i[`AXD_IMM_MSB:`AXD_IMM_LSB];

    // Timer count load word
    assign hit_load_timer = instr_valid_i && (instr_i == `AXD_OPC_LOAD_TIMER);
    // Store-with-XOR: fixed top six bits, any immediate
    assign hit_store_xor = instr_valid_i && (opc_hi == `AXD_OPC_STORE_XOR_HI);
    // Clock control write word
    assign hit_clock_ctl = instr_valid_i && (instr_i == `AXD_OPC_CLOCK_CTL);
    // Timer option write word
    assign hit_timer_opt = instr_valid_i && (instr_i == `AXD_OPC_TIMER_OPT);
    // Any of the four; the encodings never overlap
    assign hit_any = hit_load_timer || hit_store_xor || hit_clock_ctl || hit_timer_opt;

    // Transfer kind for the status register
    assign op_now = hit_load_timer ? axd_pkg::op_load_timer_count :
        hit_store_xor ? axd_pkg::op_store_acc_xor :
        hit_clock_ctl ? axd_pkg::op_write_clock_ctl :
        hit_timer_opt ? axd_pkg::op_write_timer_opt :
        axd_pkg::op_none;

    // XOR of the present index with the immediate
    // Reads the flop output, so the old index is used
    assign file_index_nxt = file_index_o ^ imm_nib;

    // Timer count, loaded from the accumulator
    // Each destination is one loadable register
    axd_ldreg #(
        .WIDTH(4),
        .RST_VAL(`AXD_NIB_RST)
    ) u_timer_count (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .load_i(hit_load_timer),
        .data_i(acc_i),
        .q_o(timer_count_o)
    );

    // Reload register, loaded in the same cycle
    axd_ldreg #(
        .WIDTH(4),
        .RST_VAL(`AXD_NIB_RST)
    ) u_timer_reload (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .load_i(hit_load_timer),
        .data_i(acc_i),
        .q_o(timer_count_reload_o)
    );

    // Clock control register
    axd_ldreg #(
        .WIDTH(4),
        .RST_VAL(`AXD_NIB_RST)
    ) u_clock_ctl (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .load_i(hit_clock_ctl),
        .data_i(acc_i),
        .q_o(clock_control_reg_o)
    );

    // Timer option bit, takes accumulator bit 0 only
    axd_ldreg #(
        .WIDTH(1),
        .RST_VAL(`AXD_TOPT_RST)
    ) u_timer_opt (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .load_i(hit_timer_opt),
        .data_i(acc_i[0]),
        .q_o(timer_option_reg_o)
    );

    // File index, rewritten by store-with-XOR
    axd_ldreg #(
        .WIDTH(4),
        .RST_VAL(`AXD_NIB_RST)
    ) u_file_index (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .load_i(hit_store_xor),
        .data_i(file_index_nxt),
        .q_o(file_index_o)
    );

    // RAM strobe follows a store-with-XOR by one stage
    // Address and data hold between stores
    assign ram_we_d = hit_store_xor;
    // Address latched from the data pointer on a store
    assign ram_addr_d = hit_store_xor ? ram_pointer_i : ram_addr_q;
    // Accumulator nibble latched on a store
    assign ram_wdata_d = hit_store_xor ? acc_i : ram_wdata_q;

    // None of these transfers writes the accumulator
    assign acc_we_d = 1'b0;
    // No carry effect
    assign carry_we_d = 1'b0;
    // No skip
    assign skip_d = 1'b0;
    // Every transfer completes in one cycle
    assign done_d = hit_any;

    // Count transfers while counting is enabled
    // Wraps at the counter width
    assign xfer_cnt_d = (hit_any && ctrl_en_q) ? xfer_cnt_q + 1'b1 : xfer_cnt_q;
    // Remember the kind of the latest transfer
    assign last_op_d = hit_any ? op_now : last_op_q;

    // Software write to the control register
    assign ctrl_wr = reg_we_i && (reg_addr_i == `AXD_OFS_CTRL);
    // Enable bit taken from the write data
    assign ctrl_en_d = ctrl_wr ? reg_wdata_i[`AXD_CTRL_EN_BIT] : ctrl_en_q;

    // Read selection by offset
    // Unused offsets read as zero
    assign rd_mux = (reg_addr_i == `AXD_OFS_CTRL) ? {7'h00, ctrl_en_q} :
        (reg_addr_i == `AXD_OFS_TIMER_COUNT) ? {4'h0, timer_count_o} :
        (reg_addr_i == `AXD_OFS_TIMER_RELOAD) ? {4'h0, timer_count_reload_o} :
        (reg_addr_i == `AXD_OFS_CLOCK_CTL) ? {4'h0, clock_control_reg_o} :
        (reg_addr_i == `AXD_OFS_TIMER_OPT) ? {7'h00, timer_option_reg_o} :
        (reg_addr_i == `AXD_OFS_FILE_INDEX) ? {4'h0, file_index_o} :
        (reg_addr_i == `AXD_OFS_STATUS) ? {5'h00, last_op_q} :
        (reg_addr_i == `AXD_OFS_XFER_COUNT) ? 8'(xfer_cnt_q) :
        8'h00;
    // Read data stands only in the cycle after the strobe
    assign reg_rdata_d = reg_re_i ? rd_mux : 8'h00;

    // Control and status state
    // Counting starts enabled after reset
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_en_q <= `AXD_CTRL_RST;
            last_op_q <= axd_pkg::op_none;
            xfer_cnt_q <= CNT_W'(`AXD_CNT_RST);
        end else begin
            ctrl_en_q <= ctrl_en_d;
            last_op_q <= last_op_d;
            xfer_cnt_q <= xfer_cnt_d;
        end
    end

    // RAM write port
    // Strobe lasts one cycle per store
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ram_we_q <= 1'b0;
            ram_addr_q <= '0;
            ram_wdata_q <= `AXD_NIB_RST;
        end else begin
            ram_we_q <= ram_we_d;
            ram_addr_q <= ram_addr_d;
            ram_wdata_q <= ram_wdata_d;
        end
    end

    // Core side-effect requests
    // Kept as flops so every output is registered
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            acc_we_q <= 1'b0;
            carry_we_q <= 1'b0;
            skip_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            acc_we_q <= acc_we_d;
            carry_we_q <= carry_we_d;
            skip_q <= skip_d;
            done_q <= done_d;
        end
    end

    // Read data register
    // Zero outside the answer cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            reg_rdata_q <= 8'h00;
        end else begin
            reg_rdata_q <= reg_rdata_d;
        end
    end

    // Outputs straight from their flops
    assign ram_we_o = ram_we_q;
    assign ram_addr_o = ram_addr_q;
    assign ram_wdata_o = ram_wdata_q;
    assign acc_we_o = acc_we_q;
    assign carry_we_o = carry_we_q;
    assign skip_o = skip_q;
    assign done_o = done_q;
    assign reg_rdata_o = reg_rdata_q;

endmodule

// File: test/axd_checker.sv
// Transfer decoder checker
`timescale 1ns/10ps
`include "axd_regs.svh"
module axd_checker #(
    parameter int PTR_W = 6
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic instr_valid_i,
    input wire logic [9:0] instr_i,
    input wire logic [3:0] acc_i,
    input wire logic [PTR_W-1:0] ram_pointer_i,
    input wire logic ram_we_o,
    input wire logic [PTR_W-1:0] ram_addr_o,
    input wire logic [3:0] ram_wdata_o,
    input wire logic [3:0] timer_count_o,
    input wire logic [3:0] timer_count_reload_o,
    input wire logic [3:0] clock_control_reg_o,
    input wire logic timer_option_reg_o,
    input wire logic [3:0] file_index_o,
    input wire logic acc_we_o,
    input wire logic carry_we_o,
    input wire logic skip_o,
    input wire logic done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Store-with-XOR issued
    sequence s_store;
        instr_valid_i && (instr_i[`AXD_OPC_HI_MSB:`AXD_OPC_HI_LSB] == `AXD_OPC_STORE_XOR_HI);
    endsequence
    // Timer count load issued
    sequence s_load;
        instr_valid_i && (instr_i == `AXD_OPC_LOAD_TIMER);
    endsequence
    // Clock control write issued
    sequence s_clock;
        instr_valid_i && (instr_i == `AXD_OPC_CLOCK_CTL);
    endsequence
    // Timer option write issued
    sequence s_option;
        instr_valid_i && (instr_i == `AXD_OPC_TIMER_OPT);
    endsequence
    store_ram_a:
    assert property (s_store |=> ram_we_o && (ram_wdata_o == $past(acc_i))
        && (ram_addr_o == $past(ram_pointer_i))) else $error("store write wrong");
    index_xor_a:
    assert property (s_store |=> file_index_o == ($past(file_index_o) ^ $past(instr_i[3:0])))
        else $error("index xor wrong");
    timer_load_a:
    assert property (s_load |=> (timer_count_o == $past(acc_i))
        && (timer_count_reload_o == $past(acc_i)) && done_o) else $error("timer load wrong");
    clock_ctl_a:
    assert property (s_clock |=> clock_control_reg_o == $past(acc_i))
        else $error("clock control wrong");
    timer_opt_a:
    assert property (s_option |=> timer_option_reg_o == $past(acc_i[0]))
        else $error("timer option wrong");
    ram_quiet_a:
    assert property (!(instr_valid_i && (instr_i[9:4] == `AXD_OPC_STORE_XOR_HI)) |=> !ram_we_o)
        else $error("stray ram write");
    acc_hold_a:
    assert property (!acc_we_o) else $error("accumulator written");
    no_flags_a:
    assert property (!carry_we_o && !skip_o) else $error("carry or skip raised");
endmodule
bind axd_decode axd_checker chk (.*);

// File: test/tb_accumulator_transfer_decode.sv
// Transfer decoder bench
`timescale 1ns/10ps
`include "axd_regs.svh"
module tb_accumulator_transfer_decode;
    // Clock, reset and instruction issue
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic v = 1'b0;
    logic [9:0] w = 10'h000;
    logic [3:0] ac = 4'h0;
    logic [5:0] p = 6'h00;
    // Register port drive
    logic [3:0] ra = 4'h0;
    logic [7:0] rw = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    // Design outputs
    logic [3:0] tc, tr, cc, fi, rdat;
    logic [5:0] radr;
    logic po, rwe, awe, cwe, sk, dn;
    logic [7:0] rdo, d8;
    // Encodings by kind; kind 1 is built with its immediate, kind 4 is no transfer
    logic [9:0] ops [5] = '{`AXD_OPC_LOAD_TIMER, 10'h000, `AXD_OPC_CLOCK_CTL,
        `AXD_OPC_TIMER_OPT, 10'h001};
    // Reference model
    integer m_tc = 0, m_tr = 0, m_cc = 0, m_po = 0, m_fi = 0, m_cnt = 0;
    integer m_op = axd_pkg::op_none;
    logic [9:0] ram_q [$];
    logic [9:0] e10;
    logic [3:0] a, j;
    logic [5:0] pv;
    integer miscompares = 0, checked = 0, seed = 51331, i, k;
    always #12.5 clk_i = ~clk_i;
    axd_decode dut (.clk_i(clk_i), .srst_i(srst_i), .instr_valid_i(v), .instr_i(w),
        .acc_i(ac), .ram_pointer_i(p), .ram_we_o(rwe), .ram_addr_o(radr), .ram_wdata_o(rdat),
        .timer_count_o(tc), .timer_count_reload_o(tr), .clock_control_reg_o(cc),
        .timer_option_reg_o(po), .file_index_o(fi), .acc_we_o(awe), .carry_we_o(cwe),
        .skip_o(sk), .done_o(dn), .reg_addr_i(ra), .reg_wdata_i(rw), .reg_we_i(we),
        .reg_re_i(re), .reg_rdata_o(rdo));
    // Count and report one comparison
    task automatic note(input logic [10:0] g, input logic [10:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Destination register contents
    task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
        note({3'h0, g}, {3'h0, e});
    endtask
    // RAM write port
    task automatic cmp_ram(input logic [10:0] g, input logic [10:0] e);
        note(g, e);
    endtask
    // Core side-effect requests
    task automatic cmp_flags(input logic [3:0] g, input logic [3:0] e);
        note({7'h00, g}, {7'h00, e});
    endtask
    // Register port read data
    task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
        note({3'h0, g}, {3'h0, e});
    endtask
    // One-cycle write strobe
    task automatic bus_wr(input logic [3:0] adr, input logic [7:0] dat);
        @(posedge clk_i);
        ra <= adr;
        rw <= dat;
        we <= 1'b1;
        @(posedge clk_i);
        we <= 1'b0;
    endtask
    // One-cycle read strobe, data taken in the cycle after it
    task automatic bus_rd(input logic [3:0] adr, output logic [7:0] dat);
        @(posedge clk_i);
        ra <= adr;
        re <= 1'b1;
        @(posedge clk_i);
        re <= 1'b0;
        #1;
        dat = rdo;
    endtask
    task give_verdict;
        if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Issue each transfer kind with random data, then the register port
    initial begin
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        cmp_reg({tc, tr}, 8'h00);
        cmp_reg({4'h0, fi}, 8'h00);
        for (i = 0; i < 80; i++) begin
            k = i % 5;
            a = 4'($random(seed));
            j = 4'($random(seed));
            pv = 6'($random(seed));
            @(posedge clk_i);
            v <= 1'b1;
            ac <= a;
            p <= pv;
            w <= (k == 1) ? {`AXD_OPC_STORE_XOR_HI, j} : ops[k];
            case (k)
                0: begin
                    m_tc = a;
                    m_tr = a;
                    m_op = axd_pkg::op_load_timer_count;
                end
                1: begin
                    ram_q.push_back({pv, a});
                    m_fi = m_fi ^ j;
                    m_op = axd_pkg::op_store_acc_xor;
                end
                2: begin
                    m_cc = a;
                    m_op = axd_pkg::op_write_clock_ctl;
                end
                3: begin
                    m_po = a[0];
                    m_op = axd_pkg::op_write_timer_opt;
                end
                default: begin
                end
            endcase
            if (k != 4) m_cnt++;
            @(posedge clk_i);
            v <= 1'b0;
            #1;
            cmp_reg({tc, tr}, {4'(m_tc), 4'(m_tr)});
            cmp_reg({4'h0, cc}, 8'(m_cc));
            cmp_reg({7'h00, po}, 8'(m_po));
            cmp_reg({4'h0, fi}, 8'(m_fi));
            if (k == 1) begin
                e10 = ram_q.pop_front();
                cmp_ram({rwe, radr, rdat}, {1'b1, e10});
            end else begin
                cmp_ram({rwe, 10'h000}, 11'h000);
            end
            cmp_flags({awe, cwe, sk, dn}, {3'h0, k != 4});
        end
        bus_rd(`AXD_OFS_XFER_COUNT, d8);
        cmp_rd(d8, 8'(m_cnt));
        bus_rd(`AXD_OFS_STATUS, d8);
        cmp_rd(d8, 8'(m_op));
        bus_rd(`AXD_OFS_CTRL, d8);
        cmp_rd(d8, {7'h00, `AXD_CTRL_RST});
        bus_rd(`AXD_OFS_FILE_INDEX, d8);
        cmp_rd(d8, 8'(m_fi));
        bus_rd(`AXD_OFS_TIMER_RELOAD, d8);
        cmp_rd(d8, 8'(m_tr));
        bus_wr(`AXD_OFS_CTRL, 8'h00);
        a = 4'($random(seed));
        @(posedge clk_i);
        v <= 1'b1;
        ac <= a;
        w <= `AXD_OPC_CLOCK_CTL;
        m_cc = a;
        @(posedge clk_i);
        v <= 1'b0;
        bus_rd(`AXD_OFS_XFER_COUNT, d8);
        cmp_rd(d8, 8'(m_cnt));
        bus_rd(`AXD_OFS_CLOCK_CTL, d8);
        cmp_rd(d8, 8'(m_cc));
        give_verdict;
    end
endmodule
